// File: hdl/mls_regs.vh
`ifndef MLS_REGS_VH
`define MLS_REGS_VH
// Register byte offsets
`define MLS_OFS_CTRL   5'h00
`define MLS_OFS_CHSEL  5'h04
`define MLS_OFS_CHACT  5'h08
`define MLS_OFS_STAT   5'h0c
`define MLS_OFS_CMD    5'h10
`define MLS_OFS_PTR    5'h14
`define MLS_OFS_UNRD   5'h18
`define MLS_OFS_TLEFT  5'h1c
// Control fields
`define MLS_CTRL_WRAP  0
`define MLS_CTRL_TRIG  2:1
`define MLS_CTRL_PER   6:3
// Command bits
`define MLS_CMD_CONF   0
`define MLS_CMD_DNLD   1
`define MLS_CMD_PWRUP  2
// Status bits
`define MLS_ST_FULL    0
`define MLS_ST_HALT    1
`define MLS_ST_OVWR    2
`define MLS_ST_WARN    3
`define MLS_ST_LOGDIS  4
`define MLS_ST_GATE    5
`define MLS_ST_BUSY    6
// Reset values
`define MLS_WRAP_RST   1'h0
`define MLS_TRIG_RST   2'h0
`define MLS_PER_RST    4'h0
`define MLS_CHSEL_RST  16'h0000
`define MLS_CHACT_RST  8'hff
// Encodings
`define MLS_TRIG_ALWAYS 2'h0
`define MLS_TRIG_HIGH   2'h1
`define MLS_TRIG_LOW    2'h2
`define MLS_SEL_OFF     2'h0
`define MLS_SEL_INST    2'h1
`define MLS_SEL_AVG     2'h2
// Record memory capacity in words
`define MLS_MEM_WORDS  17'h10000
// Recording periods in seconds, by period index
`define MLS_PER_S0     12'h001
`define MLS_PER_S1     12'h002
`define MLS_PER_S2     12'h005
`define MLS_PER_S3     12'h00a
`define MLS_PER_S4     12'h00f
`define MLS_PER_S5     12'h014
`define MLS_PER_S6     12'h01e
`define MLS_PER_S7     12'h03c
`define MLS_PER_S8     12'h078
`define MLS_PER_S9     12'h12c
`define MLS_PER_S10    12'h258
`define MLS_PER_S11    12'h384
`define MLS_PER_S12    12'h4b0
`define MLS_PER_S13    12'h708
`define MLS_PER_S14    12'he10
`endif

// File: hdl/mls_sync.v
`timescale 1ns/1ps
`default_nettype none
module mls_sync (
    // Clock and reset
    input  wire mclk,
    input  wire rst_b,
    // Pin in, filtered level out
    input  wire pin,
    output reg  level
);
    reg s1;
    reg s2;
    reg s3;

    // Three stages; level moves only once stages two and three agree
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule // mls_sync
`default_nettype wire

// File: hdl/mls_div.v
`timescale 1ns/1ps
`default_nettype none
module mls_div (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_b,
    // Operands, sampled at each pass start
    input  wire [28:0] dividend,
    input  wire [3:0]  divisor,
    // Quotient of the last finished pass
    output reg  [28:0] quo
);
    reg  [28:0] num;
    reg  [3:0]  den;
    reg  [3:0]  rem;
    reg  [28:0] q;
    reg  [4:0]  cnt;
    wire [4:0]  trial = {rem, num[28]};
    wire        qbit  = (trial >= {1'b0, den});

    // Free-running restoring divider; a result every 30 cycles is ample
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            num <= 29'h0;
            den <= 4'h1;
            rem <= 4'h0;
            q   <= 29'h0;
            cnt <= 5'h0;
            quo <= 29'h0;
        end else if (cnt == 5'h0) begin
            num <= dividend;
            den <= (divisor == 4'h0) ? 4'h1 : divisor;
            rem <= 4'h0;
            q   <= 29'h0;
            cnt <= 5'h1d;
        end else begin
            rem <= qbit ? (trial[3:0] - den) : trial[3:0];
            q   <= {q[27:0], qbit};
            num <= {num[27:0], 1'b0};
            cnt <= cnt - 5'h1;
            if (cnt == 5'h1) begin
                quo <= {q[27:0], qbit};
            end
        end
    end
endmodule // mls_div
`default_nettype wire

// File: hdl/mls_sched.v
// Functional notes
// - Stop-on-full halts recording when memory is full; warning pending until confirm.
// - After a stop-on-full halt, resume only once results are downloaded.
// - A pending full or overwrite warning is raised again at every power-up.
// - Downloading before memory fills means no full or overwrite warning.
// - Wrap-around policy continues writing from the first address, overwriting.
// - Wrap-around warns on first overwrite only; pending until confirm.
// - When full, status shows halted or overwriting instead of time left.
// - Always mode records every interval; high mode only while gate is high.
// - Low-level gating records only while the gate input is low.
// - Interval chosen from fifteen fixed settings, one second to sixty minutes.
// - Recording instants are aligned to the real-time clock.
// - Interval shorter than sampling stores the latest sample again.
// - Each of eight channels: off, instantaneous or averaged value stored.
// - Channels configured inactive are excluded from recording selection.
// - Time left from free memory, interval and recorded channel count.
// - No selected channel shows logging-disabled instead of time left.
// - Downloaded records count as free space, overwritten without warning.
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`include "mls_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module mls_sched (
    // Clock and reset
    input  wire         mclk,
    input  wire         rst_b,
    // Avalon-MM slave
    input  wire [4:0]   avs_address,
    input  wire         avs_read,
    input  wire         avs_write,
    input  wire [31:0]  avs_writedata,
    output reg  [31:0]  avs_readdata,
    output reg          avs_waitrequest,
    // Real-time clock, same clock domain
    input  wire         rtc_tick,
    input  wire [5:0]   rtc_sec,
    input  wire [5:0]   rtc_min,
    // Pins from outside
    input  wire         gate_pin,
    input  wire         key_pin,
    // Channel results, 16 bits per channel
    input  wire [127:0] ch_inst,
    input  wire [127:0] ch_avg,
    // Record memory write port
    input  wire         rec_ready,
    output reg          rec_we,
    output reg  [15:0]  rec_addr,
    output reg  [15:0]  rec_data,
    // Warning awaiting confirmation
    output reg          warn_pending
);
    localparam S_IDLE  = 2'h0;
    localparam S_SCAN  = 2'h1;
    localparam S_WRITE = 2'h2;

    reg         ctrl_wrap;
    reg [1:0]   ctrl_trig;
    reg [3:0]   ctrl_per;
    reg [15:0]  ch_sel;
    reg [7:0]   ch_act;
    reg [16:0]  unread;
    reg         full;
    reg         ovw_seen;
    reg [1:0]   state;
    reg [2:0]   ch_idx;
    reg         key_prev;
    wire        gate_lvl;
    wire        key_lvl;
    wire [28:0] quo;
    wire [15:0] eff_sel;
    reg  [3:0]  nch;
    reg  [11:0] psec;
    reg         aligned;
    integer     i;

    // Gate and confirm key come from pins
    mls_sync u_gate (
        .mclk  (mclk),
        .rst_b (rst_b),
        .pin   (gate_pin),
        .level (gate_lvl)
    );
    mls_sync u_key (
        .mclk  (mclk),
        .rst_b (rst_b),
        .pin   (key_pin),
        .level (key_lvl)
    );

    // Inactive inputs never reach the recorder
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_sel
            assign eff_sel[2*g+1:2*g] = ch_act[g] ? ch_sel[2*g+1:2*g] : `MLS_SEL_OFF;
        end
    endgenerate

    // Count of recorded channels
    always @* begin
        nch = 4'h0;
        for (i = 0; i < 8; i = i + 1) begin
            if (eff_sel[2*i +: 2] != `MLS_SEL_OFF) begin
                nch = nch + 4'h1;
            end
        end
    end

    // Period table and clock alignment
    always @* begin
        aligned = 1'b0;
        case (ctrl_per)
            4'h0: psec = `MLS_PER_S0;
            4'h1: psec = `MLS_PER_S1;
            4'h2: psec = `MLS_PER_S2;
            4'h3: psec = `MLS_PER_S3;
            4'h4: psec = `MLS_PER_S4;
            4'h5: psec = `MLS_PER_S5;
            4'h6: psec = `MLS_PER_S6;
            4'h7: psec = `MLS_PER_S7;
            4'h8: psec = `MLS_PER_S8;
            4'h9: psec = `MLS_PER_S9;
            4'ha: psec = `MLS_PER_S10;
            4'hb: psec = `MLS_PER_S11;
            4'hc: psec = `MLS_PER_S12;
            4'hd: psec = `MLS_PER_S13;
            default: psec = `MLS_PER_S14;
        endcase
        // Short periods divide the minute, long ones the hour
        if (psec < `MLS_PER_S7) begin
            aligned = (({6'h00, rtc_sec} % psec) == 12'h000);
        end else begin
            aligned = (rtc_sec == 6'h00) &&
                      (({6'h00, rtc_min} % (psec / `MLS_PER_S7)) == 12'h000);
        end
    end

    // Time left: free words times period over recorded channels
    wire [16:0] free_words = `MLS_MEM_WORDS - unread;
    mls_div u_div (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .dividend ({12'h000, free_words} * {17'h00000, psec}),
        .divisor  (nch),
        .quo      (quo)
    );

    wire gate_ok = (ctrl_trig == `MLS_TRIG_ALWAYS) ||
                   ((ctrl_trig == `MLS_TRIG_HIGH) && gate_lvl) ||
                   ((ctrl_trig == `MLS_TRIG_LOW) && !gate_lvl);
    wire halted  = full && !ctrl_wrap;
    wire trigger = rtc_tick && aligned && gate_ok && (nch != 4'h0) && !halted;

    // Bus decode; the master holds its request until waitrequest drops
    wire bus_req  = (avs_read || avs_write) && avs_waitrequest;
    wire bus_wr   = avs_write && !avs_waitrequest;
    wire cmd_wr   = bus_wr && (avs_address == `MLS_OFS_CMD);
    wire confirm  = (cmd_wr && avs_writedata[`MLS_CMD_CONF]) || (key_lvl && !key_prev);
    wire dnld     = cmd_wr && avs_writedata[`MLS_CMD_DNLD];
    wire pwrup    = cmd_wr && avs_writedata[`MLS_CMD_PWRUP];
    wire wr_done  = (state == S_WRITE) && rec_ready;
    wire at_full  = (unread == `MLS_MEM_WORDS);
    wire hit_full = wr_done && !at_full && (unread == `MLS_MEM_WORDS - 17'h1);
    wire first_ow = wr_done && at_full && ctrl_wrap && !ovw_seen;
    wire [7:0] status;

    assign status = {1'b0,
                     state != S_IDLE,
                     gate_lvl,
                     nch == 4'h0,
                     warn_pending,
                     full && ctrl_wrap,
                     halted,
                     full};

    // Read mux
    reg [31:0] rd_val;
    always @* begin
        case (avs_address)
            `MLS_OFS_CTRL:  rd_val = {25'h0, ctrl_per, ctrl_trig, ctrl_wrap};
            `MLS_OFS_CHSEL: rd_val = {16'h0, ch_sel};
            `MLS_OFS_CHACT: rd_val = {24'h0, ch_act};
            `MLS_OFS_STAT:  rd_val = {24'h0, status};
            `MLS_OFS_PTR:   rd_val = {16'h0, rec_addr};
            `MLS_OFS_UNRD:  rd_val = {15'h0, unread};
            // Zero stands for halted, overwriting or disabled
            `MLS_OFS_TLEFT: rd_val = (full || nch == 4'h0) ? 32'h0 : {3'h0, quo};
            default:        rd_val = 32'h0;
        endcase
    end

    // Bus slave: one wait cycle, then a single-cycle acknowledge
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else if (bus_req) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= rd_val;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Configuration registers
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_wrap <= `MLS_WRAP_RST;
            ctrl_trig <= `MLS_TRIG_RST;
            ctrl_per  <= `MLS_PER_RST;
            ch_sel    <= `MLS_CHSEL_RST;
            ch_act    <= `MLS_CHACT_RST;
            key_prev  <= 1'b0;
        end else begin
            key_prev <= key_lvl;
            if (bus_wr && avs_address == `MLS_OFS_CTRL) begin
                ctrl_wrap <= avs_writedata[`MLS_CTRL_WRAP];
                ctrl_trig <= avs_writedata[`MLS_CTRL_TRIG];
                ctrl_per  <= avs_writedata[`MLS_CTRL_PER];
            end
            if (bus_wr && avs_address == `MLS_OFS_CHSEL) begin
                ch_sel <= avs_writedata[15:0];
            end
            if (bus_wr && avs_address == `MLS_OFS_CHACT) begin
                ch_act <= avs_writedata[7:0];
            end
        end
    end

    // Fill accounting and warnings; a download beats a same-cycle write, a warning set beats a confirm
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            unread       <= 17'h0;
            full         <= 1'b0;
            ovw_seen     <= 1'b0;
            warn_pending <= 1'b0;
        end else begin
            if (dnld) begin
                // Download frees everything; a word written now still counts
                unread   <= wr_done ? 17'h1 : 17'h0;
                full     <= 1'b0;
                ovw_seen <= 1'b0;
            end else if (bus_wr && avs_address == `MLS_OFS_UNRD) begin
                // Restore after power-up; capacity caps the count
                unread   <= (avs_writedata[16:0] > `MLS_MEM_WORDS) ?
                            `MLS_MEM_WORDS : avs_writedata[16:0];
                full     <= (avs_writedata[16:0] >= `MLS_MEM_WORDS);
                ovw_seen <= (avs_writedata[16:0] >= `MLS_MEM_WORDS) && ctrl_wrap;
            end else if (wr_done && !at_full) begin
                unread <= unread + 17'h1;
                if (hit_full) begin
                    full <= 1'b1;
                end
            end else if (first_ow) begin
                ovw_seen <= 1'b1;
            end
            // Warning sources
            if ((hit_full && !ctrl_wrap && !dnld) || (first_ow && !dnld)) begin
                warn_pending <= 1'b1;
            end else if (pwrup && full) begin
                warn_pending <= 1'b1;
            end else if (confirm) begin
                warn_pending <= 1'b0;
            end
        end
    end

    // Record writer: one word per recorded channel, channel order 0..7
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state    <= S_IDLE;
            ch_idx   <= 3'h0;
            rec_we   <= 1'b0;
            rec_addr <= 16'h0000;
            rec_data <= 16'h0000;
        end else begin
            case (state)
                S_IDLE: begin
                    if (bus_wr && avs_address == `MLS_OFS_PTR) begin
                        rec_addr <= avs_writedata[15:0];
                    end else if (trigger) begin
                        ch_idx <= 3'h0;
                        state  <= S_SCAN;
                    end
                end
                S_SCAN: begin
                    if (halted) begin
                        state <= S_IDLE;
                    end else if (eff_sel[2*ch_idx +: 2] != `MLS_SEL_OFF) begin
                        // Latest sample is taken as is, so repeats are stored
                        rec_data <= (eff_sel[2*ch_idx +: 2] == `MLS_SEL_AVG) ?
                                    ch_avg[16*ch_idx +: 16] :
                                    ch_inst[16*ch_idx +: 16];
                        rec_we   <= 1'b1;
                        state    <= S_WRITE;
                    end else if (ch_idx == 3'h7) begin
                        state <= S_IDLE;
                    end else begin
                        ch_idx <= ch_idx + 3'h1;
                    end
                end
                S_WRITE: begin
                    if (rec_ready) begin
                        rec_we   <= 1'b0;
                        // Address rolls over to zero past the top
                        rec_addr <= rec_addr + 16'h0001;
                        if (ch_idx == 3'h7) begin
                            state <= S_IDLE;
                        end else begin
                            ch_idx <= ch_idx + 3'h1;
                            state  <= S_SCAN;
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // mls_sched
`default_nettype wire

// File: verif/mls_sched_properties.sv
`include "mls_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module mls_sched_properties (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Register bus
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic        avs_waitrequest,
    // Event inputs
    input  wire logic        rtc_tick,
    input  wire logic        key_pin,
    // Record port and warning
    input  wire logic        rec_ready,
    input  wire logic        rec_we,
    input  wire logic [15:0] rec_addr,
    input  wire logic [15:0] rec_data,
    input  wire logic        warn_pending
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic [3:0] since_tick, since_acc, since_conf, since_pwr;
    wire logic req    = avs_read || avs_write;
    wire logic cmd_wr = avs_write && !avs_waitrequest && avs_address == `MLS_OFS_CMD;
    function automatic logic [3:0] bump(input logic [3:0] c);
        return (c == 4'hf) ? c : c + 4'h1;
    endfunction
    // Cycles since each cause; saturating so stale causes fade out
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            since_tick <= 4'hf;
            since_acc  <= 4'hf;
            since_conf <= 4'hf;
            since_pwr  <= 4'hf;
        end else begin
            since_tick <= rtc_tick ? 4'h0 : bump(since_tick);
            since_acc  <= (rec_we && rec_ready) ? 4'h0 : bump(since_acc);
            since_conf <= (key_pin || (cmd_wr && avs_writedata[1:0] != 2'h0)) ? 4'h0
                                                                             : bump(since_conf);
            since_pwr  <= (cmd_wr && avs_writedata[`MLS_CMD_PWRUP]) ? 4'h0 : bump(since_pwr);
        end
    end
    sequence s_taken;
        req && avs_waitrequest;
    endsequence
    sequence s_stalled;
        rec_we && !rec_ready;
    endsequence
    a_bus_answer: assert property (s_taken |=> !avs_waitrequest)
        else $error("bus request not answered in the next cycle");
    a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_ack_cause: assert property ($fell(avs_waitrequest) |-> $past(req))
        else $error("waitrequest dropped with no request");
    a_rec_hold: assert property (s_stalled |=> rec_we && $stable(rec_addr) && $stable(rec_data))
        else $error("record word changed before it was accepted");
    a_addr_step: assert property (rec_we && rec_ready |=> rec_addr == $past(rec_addr) + 16'h1)
        else $error("write address did not step by one");
    a_write_cause: assert property ($rose(rec_we) |-> since_tick <= 4'ha || since_acc <= 4'h9)
        else $error("record write started with no tick");
    a_warn_cause: assert property ($rose(warn_pending) |-> since_acc <= 4'h3 || since_pwr <= 4'h3)
        else $error("warning raised with no write or power-up");
    a_warn_hold: assert property ($fell(warn_pending) |-> since_conf <= 4'h6)
        else $error("warning cleared with no confirm");
endmodule // mls_sched_properties
bind mls_sched mls_sched_properties u_props (
    .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .rtc_tick(rtc_tick), .key_pin(key_pin), .rec_ready(rec_ready), .rec_we(rec_we),
    .rec_addr(rec_addr), .rec_data(rec_data), .warn_pending(warn_pending)
);
`default_nettype wire

// File: verif/mls_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mls_mem_model (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Write port from the scheduler
    input  wire logic        rec_we,
    input  wire logic [15:0] rec_addr,
    input  wire logic [15:0] rec_data,
    output var  logic        rec_ready,
    // Pace: 0 accepts at once, 1 every third cycle
    input  wire logic        slow
);
    logic [1:0]  pace;
    logic [15:0] got_addr[$];
    logic [15:0] got_data[$];
    // Slow pace mimics a busy memory page, so the writer must hold its word
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pace      <= 2'h0;
            rec_ready <= 1'b0;
        end else begin
            pace      <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
            rec_ready <= !slow || pace == 2'h2;
        end
    end
    // Log each accepted word for the bench
    always @(posedge mclk) begin
        if (rst_b && rec_we && rec_ready) begin
            got_addr.push_back(rec_addr);
            got_data.push_back(rec_data);
        end
    end
endmodule // mls_mem_model
`default_nettype wire

// File: verif/measurement_logging_scheduler_tb_top.sv
`include "mls_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module measurement_logging_scheduler_tb_top;
    logic         mclk, rst_b, avs_read, avs_write, avs_waitrequest;
    logic         rtc_tick, gate_pin, key_pin, slow, rec_we, rec_ready, warn_pending;
    logic [4:0]   avs_address;
    logic [31:0]  avs_writedata, avs_readdata, rd;
    logic [5:0]   rtc_sec, rtc_min;
    logic [15:0]  rec_addr, rec_data;
    logic [127:0] ch_inst, ch_avg;
    integer       fails, samples_checked, i;

    // Free-running system clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    mls_sched DUT (
        .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rtc_tick(rtc_tick), .rtc_sec(rtc_sec),
        .rtc_min(rtc_min), .gate_pin(gate_pin), .key_pin(key_pin), .ch_inst(ch_inst),
        .ch_avg(ch_avg), .rec_ready(rec_ready), .rec_we(rec_we), .rec_addr(rec_addr),
        .rec_data(rec_data), .warn_pending(warn_pending)
    );
    mls_mem_model MEM (
        .mclk(mclk), .rst_b(rst_b), .rec_we(rec_we), .rec_addr(rec_addr),
        .rec_data(rec_data), .rec_ready(rec_ready), .slow(slow)
    );

    task automatic conclude;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fails);
            if (fails == 0 && samples_checked > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            samples_checked++;
            if (got !== exp) begin
                fails++;
                $display("BAD %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // One bus cycle; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        integer n;
        begin
            @(posedge mclk);
            avs_address   <= a;
            avs_writedata <= d;
            avs_write     <= wr;
            avs_read      <= !wr;
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (avs_waitrequest !== 1'b0 && n < 20);
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read  <= 1'b0;
            if (avs_waitrequest !== 1'b0) begin
                fails++;
                conclude();
            end
        end
    endtask
    // One-cycle tick, then expect the total count of stored words
    task automatic tick(input logic [5:0] s, input integer total);
        integer k;
        begin
            rtc_sec  <= s;
            rtc_tick <= 1'b1;
            @(posedge mclk);
            rtc_tick <= 1'b0;
            for (k = 0; k < 80 && MEM.got_data.size() < total; k++)
                @(posedge mclk);
            repeat (12) @(posedge mclk);
            chk(32'(MEM.got_data.size()), 32'(total));
        end
    endtask
    task automatic chk_last(input logic [15:0] a, input logic [15:0] d);
        integer k;
        begin
            k = MEM.got_addr.size() - 1;
            chk({16'h0, MEM.got_addr[k]}, {16'h0, a});
            chk({16'h0, MEM.got_data[k]}, {16'h0, d});
        end
    endtask
    task automatic chk_warn(input logic exp);
        begin
            repeat (2) @(posedge mclk);
            chk({31'h0, warn_pending}, {31'h0, exp});
        end
    endtask
    task automatic chk_stat(input logic [31:0] exp);
        begin
            bus(1'b0, `MLS_OFS_STAT, 32'h0);
            chk(rd & 32'h1f, exp);
        end
    endtask
    task automatic press_key;
        begin
            key_pin <= 1'b1;
            repeat (6) @(posedge mclk);
            key_pin <= 1'b0;
            repeat (6) @(posedge mclk);
        end
    endtask

    task automatic sc_reset;
        begin
            bus(1'b0, `MLS_OFS_CTRL, 32'h0);
            chk(rd, 32'h0);
            bus(1'b0, `MLS_OFS_CHACT, 32'h0);
            chk(rd, 32'hff);
            bus(1'b1, `MLS_OFS_STAT, 32'h1f);
            chk_stat(32'h10);
            bus(1'b0, `MLS_OFS_TLEFT, 32'h0);
            chk(rd, 32'h0);
        end
    endtask
    // Channel 0 code 3 (instantaneous), channel 2 averaged, 5 s period
    task automatic sc_record;
        begin
            bus(1'b1, `MLS_OFS_CHSEL, 32'h23);
            bus(1'b1, `MLS_OFS_CTRL, 32'h10);
            tick(6'h03, 0);
            tick(6'h05, 2);
            chk({16'h0, MEM.got_data[0]}, 32'h1100);
            chk_last(16'h0001, 16'h2202);
            slow <= 1'b1;
            bus(1'b1, `MLS_OFS_CHACT, 32'hfb);
            tick(6'h0a, 3);
            chk_last(16'h0002, 16'h1100);
            slow <= 1'b0;
            repeat (62) @(posedge mclk);
            bus(1'b0, `MLS_OFS_TLEFT, 32'h0);
            chk(rd, 32'h4fff1);
            chk_stat(32'h0);
        end
    endtask
    // High then low gating, 1 s period
    task automatic sc_gate;
        integer t, tot;
        begin
            for (t = 1; t <= 2; t++) begin
                bus(1'b1, `MLS_OFS_CTRL, 32'(t << 1));
                tot = MEM.got_data.size();
                gate_pin <= (t == 2);
                repeat (6) @(posedge mclk);
                tick(6'h01, tot);
                gate_pin <= (t == 1);
                repeat (6) @(posedge mclk);
                tick(6'h02, tot + 1);
            end
            gate_pin <= 1'b0;
        end
    endtask
    task automatic sc_early;
        begin
            bus(1'b1, `MLS_OFS_CTRL, 32'h0);
            bus(1'b1, `MLS_OFS_UNRD, 32'hffff);
            bus(1'b1, `MLS_OFS_CMD, 32'h2);
            tick(6'h07, MEM.got_data.size() + 1);
            chk_warn(1'b0);
            chk_stat(32'h0);
        end
    endtask
    task automatic sc_full_stop;
        integer tot;
        begin
            tot = MEM.got_data.size();
            bus(1'b1, `MLS_OFS_UNRD, 32'hffff);
            tick(6'h08, tot + 1);
            chk_warn(1'b1);
            chk_stat(32'h0b);
            bus(1'b0, `MLS_OFS_TLEFT, 32'h0);
            chk(rd, 32'h0);
            tick(6'h09, tot + 1);
            press_key();
            chk_warn(1'b0);
            bus(1'b1, `MLS_OFS_CMD, 32'h4);
            chk_warn(1'b1);
            bus(1'b1, `MLS_OFS_CMD, 32'h1);
            chk_warn(1'b0);
            bus(1'b1, `MLS_OFS_CMD, 32'h2);
            tick(6'h0b, tot + 2);
            chk_warn(1'b0);
        end
    endtask
    task automatic sc_wrap;
        integer tot;
        begin
            tot = MEM.got_data.size();
            bus(1'b1, `MLS_OFS_CTRL, 32'h1);
            bus(1'b1, `MLS_OFS_PTR, 32'hffff);
            bus(1'b1, `MLS_OFS_UNRD, 32'hffff);
            tick(6'h0c, tot + 1);
            chk_last(16'hffff, 16'h1100);
            chk_warn(1'b0);
            chk_stat(32'h05);
            tick(6'h0d, tot + 2);
            chk_last(16'h0000, 16'h1100);
            chk_warn(1'b1);
            bus(1'b1, `MLS_OFS_CMD, 32'h1);
            chk_warn(1'b0);
            tick(6'h0e, tot + 3);
            chk_last(16'h0001, 16'h1100);
            chk_warn(1'b0);
            bus(1'b1, `MLS_OFS_CMD, 32'h4);
            chk_warn(1'b1);
            press_key();
            chk_warn(1'b0);
        end
    endtask

    // Reset, then the scenarios in order
    initial begin
        fails = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        {avs_read, avs_write, rtc_tick, gate_pin, key_pin, slow} = 6'h00;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        rtc_sec = 6'h00;
        rtc_min = 6'h00;
        for (i = 0; i < 8; i++) begin
            ch_inst[16*i +: 16] = 16'h1100 + 16'(i);
            ch_avg[16*i +: 16]  = 16'h2200 + 16'(i);
        end
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        sc_reset();
        sc_record();
        sc_gate();
        sc_early();
        sc_full_stop();
        sc_wrap();
        conclude();
    end
endmodule // measurement_logging_scheduler_tb_top
`default_nettype wire
